// ==== src/oad_pkg.sv ====
//----------------------------------------------------------------------
// Package oad_pkg
//----------------------------------------------------------------------
// Purpose: Shared constants and types of the operand address decoder
// Assumes: Instruction bytes arrive one per accepted handshake
// Notes:   Field positions refer to the operand-addressing byte, opcode and prefix

package oad_pkg;

  //--------------------------------------------------------------------
  // Addressing-form field values
  //--------------------------------------------------------------------
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8  = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG    = 2'h3;

  // Operand-select code that means a direct address in form 00
  localparam logic [2:0] RM_DIRECT  = 3'h6;

  //--------------------------------------------------------------------
  // Field positions in the operand-addressing byte, opcode and prefix
  //--------------------------------------------------------------------
  localparam int MOD_HI     = 7;
  localparam int MOD_LO     = 6;
  localparam int REG_HI     = 5;
  localparam int REG_LO     = 3;
  localparam int RM_HI      = 2;
  localparam int RM_LO      = 0;
  localparam int WIDTH_BIT  = 0;
  localparam int PSEG_HI    = 4;
  localparam int PSEG_LO    = 3;

  // Prefix pattern 001xx110 as mask and match
  localparam logic [7:0] PREFIX_MASK  = 8'hE7;
  localparam logic [7:0] PREFIX_MATCH = 8'h26;

  //--------------------------------------------------------------------
  // Cycle counts and base instruction length
  //--------------------------------------------------------------------
  localparam logic [2:0] EA_CYCLES      = 3'h4;
  localparam logic [8:0] WORD_MEM_EXTRA = 9'h004;
  localparam logic [2:0] BASE_INSN_LEN  = 3'h2;

  //--------------------------------------------------------------------
  // Values after reset
  //--------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [2:0]  RST_CNT   = 3'h0;
  localparam logic [8:0]  RST_CYC   = 9'h000;

  //--------------------------------------------------------------------
  // Segment selection, coded as in the override prefix
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEG_EXTRA = 2'b00,
    SEG_CODE  = 2'b01,
    SEG_STACK = 2'b10,
    SEG_DATA  = 2'b11
  } oad_seg_t;

  //--------------------------------------------------------------------
  // Byte collection and calculation states
  //--------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_MODRM  = 3'b001,
    ST_DISPLO = 3'b010,
    ST_DISPHI = 3'b011,
    ST_CALC   = 3'b100,
    ST_DONE   = 3'b101
  } oad_state_t;

endpackage : oad_pkg

// ==== src/oad_reg_select.sv ====
//----------------------------------------------------------------------
// Module oad_reg_select
//----------------------------------------------------------------------
// Purpose: Map a three-bit register code to a register and byte lane
// Assumes: Purely combinational, used for both register fields
// Notes:   Index 0..7 orders accumulator, count, data, base, stack
//          pointer, frame, source index, dest index

`timescale 1ns/1ps

module oad_reg_select (
  // Code and width
  input  wire logic [2:0] sel,
  input  wire logic       wide,
  // Selected register
  output logic      [2:0] regIndex,
  output logic            highByte,
  output logic            byteSel
);

  // Word codes name registers directly; byte codes fold onto the
  // first four registers, upper half picking the high byte
  always_comb begin
    if (wide) begin
      regIndex = sel;
      highByte = 1'b0;
      byteSel  = 1'b0;
    end else begin
      regIndex = {1'b0, sel[1:0]};
      highByte = sel[2];
      byteSel  = 1'b1;
    end
  end

endmodule : oad_reg_select

// ==== src/oad_operand_decoder.sv ====
//----------------------------------------------------------------------
// Module oad_operand_decoder
//----------------------------------------------------------------------
// Purpose: Collect prefix, opcode, addressing byte and displacement,
//          then form the effective address, segment and operands
// Assumes: Register values are stable while the calculation runs
// Notes:   Width bit is bit 0 of the opcode byte

`timescale 1ns/1ps

module oad_operand_decoder (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Instruction byte stream
  input  wire logic        byteValid,
  input  wire logic [7:0]  byteData,
  output logic             byteReady,
  // Register file values
  input  wire logic [15:0] baseReg,
  input  wire logic [15:0] frameReg,
  input  wire logic [15:0] srcIndex,
  input  wire logic [15:0] destIndex,
  // Instruction attributes
  input  wire logic        stringDest,
  input  wire logic        memTransfer,
  input  wire logic [7:0]  byteCycles,
  // Decode results
  output logic             decodeDone,
  output logic [7:0]       opcode,
  output logic [15:0]      effectiveAddress,
  output oad_pkg::oad_seg_t segSelect,
  output logic             memOperand,
  output logic             overrideSeen,
  output logic [1:0]       dispCount,
  output logic [2:0]       immStart,
  output logic [8:0]       execCycles,
  // Register operand selection
  output logic [2:0]       regIndex,
  output logic             regHigh,
  output logic             regByte,
  output logic [2:0]       rmIndex,
  output logic             rmHigh,
  output logic             rmByte
);

  //--------------------------------------------------------------------
  // Functions
  //--------------------------------------------------------------------

  // Number of displacement bytes for a form and select pair
  function automatic logic [1:0] dispLen(input logic [1:0] md,
                                         input logic [2:0] rm);
    logic [1:0] n;
    n = 2'h0;
    if (md == oad_pkg::MOD_DISP8) begin
      n = 2'h1;
    end else if (md == oad_pkg::MOD_DISP16) begin
      n = 2'h2;
    end else if (md == oad_pkg::MOD_NODISP &&
                 rm == oad_pkg::RM_DIRECT) begin
      n = 2'h2;
    end
    return n;
  endfunction : dispLen

  // Displacement value in 16 bits
  function automatic logic [15:0] dispValue(input logic [1:0] md,
                                            input logic [2:0] rm,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [15:0] v;
    v = 16'h0000;
    if (md == oad_pkg::MOD_DISP8) begin
      v = {{8{lo[7]}}, lo};
    end else if (dispLen(md, rm) == 2'h2) begin
      v = {hi, lo};
    end
    return v;
  endfunction : dispValue

  // True when the frame register takes part in the address
  function automatic logic usesFrame(input logic [1:0] md,
                                     input logic [2:0] rm);
    logic f;
    f = 1'b0;
    if (rm == 3'h2 || rm == 3'h3) begin
      f = 1'b1;
    end else if (rm == oad_pkg::RM_DIRECT &&
                 md != oad_pkg::MOD_NODISP) begin
      f = 1'b1;
    end
    return f;
  endfunction : usesFrame

  //--------------------------------------------------------------------
  // State and captured bytes
  //--------------------------------------------------------------------
  oad_pkg::oad_state_t state_q;
  oad_pkg::oad_state_t state_d;
  logic [2:0]  calcCnt_q;
  logic [7:0]  opcode_q;
  logic [7:0]  modrm_q;
  logic [7:0]  dispLo_q;
  logic [7:0]  dispHi_q;
  logic        override_q;
  logic [1:0]  overrideSeg_q;
  logic        accept;
  logic        isPrefix;
  logic [1:0]  modField;
  logic [2:0]  rmField;
  logic [2:0]  regField;
  logic        wide;
  logic [15:0] disp;
  logic [15:0] eaCalc;
  oad_pkg::oad_seg_t segCalc;
  logic        lastCalc;
  logic [2:0]  selRegIndex;
  logic        selRegHigh;
  logic        selRegByte;
  logic [2:0]  selRmIndex;
  logic        selRmHigh;
  logic        selRmByte;

  // Result registers
  logic        done_q;
  logic [15:0] ea_q;
  oad_pkg::oad_seg_t seg_q;
  logic        memOp_q;
  logic        ovrOut_q;
  logic [1:0]  dispCnt_q;
  logic [2:0]  immStart_q;
  logic [8:0]  cycles_q;
  logic [2:0]  regIndex_q;
  logic        regHigh_q;
  logic        regByte_q;
  logic [2:0]  rmIndex_q;
  logic        rmHigh_q;
  logic        rmByte_q;

  //--------------------------------------------------------------------
  // Field extraction and handshake
  //--------------------------------------------------------------------
  assign modField  = modrm_q[oad_pkg::MOD_HI:oad_pkg::MOD_LO];
  assign rmField   = modrm_q[oad_pkg::RM_HI:oad_pkg::RM_LO];
  assign regField  = modrm_q[oad_pkg::REG_HI:oad_pkg::REG_LO];
  assign wide      = opcode_q[oad_pkg::WIDTH_BIT];
  assign byteReady = (state_q == oad_pkg::ST_OPCODE) ||
                     (state_q == oad_pkg::ST_MODRM)  ||
                     (state_q == oad_pkg::ST_DISPLO) ||
                     (state_q == oad_pkg::ST_DISPHI);
  assign accept    = byteValid && byteReady;
  assign isPrefix  = (byteData & oad_pkg::PREFIX_MASK) ==
                     oad_pkg::PREFIX_MATCH;
  assign lastCalc  = (state_q == oad_pkg::ST_CALC) &&
                     (calcCnt_q == oad_pkg::EA_CYCLES - 3'h1);

  //--------------------------------------------------------------------
  // Register operand decoders
  //--------------------------------------------------------------------
  oad_reg_select uRegSel (
    .sel      (regField),
    .wide     (wide),
    .regIndex (selRegIndex),
    .highByte (selRegHigh),
    .byteSel  (selRegByte)
  );

  oad_reg_select uRmSel (
    .sel      (rmField),
    .wide     (wide),
    .regIndex (selRmIndex),
    .highByte (selRmHigh),
    .byteSel  (selRmByte)
  );

  //--------------------------------------------------------------------
  // Byte collection state machine
  //--------------------------------------------------------------------

  // Next state from accepted bytes and the calculation counter
  always_comb begin
    state_d = state_q;
    case (state_q)
      oad_pkg::ST_OPCODE: begin
        if (accept && !isPrefix) begin
          state_d = oad_pkg::ST_MODRM;
        end
      end
      oad_pkg::ST_MODRM: begin
        if (accept) begin
          if (dispLen(byteData[oad_pkg::MOD_HI:oad_pkg::MOD_LO],
                      byteData[oad_pkg::RM_HI:oad_pkg::RM_LO]) ==
              2'h0) begin
            state_d = oad_pkg::ST_CALC;
          end else begin
            state_d = oad_pkg::ST_DISPLO;
          end
        end
      end
      oad_pkg::ST_DISPLO: begin
        if (accept) begin
          if (dispLen(modField, rmField) == 2'h2) begin
            state_d = oad_pkg::ST_DISPHI;
          end else begin
            state_d = oad_pkg::ST_CALC;
          end
        end
      end
      oad_pkg::ST_DISPHI: begin
        if (accept) begin
          state_d = oad_pkg::ST_CALC;
        end
      end
      oad_pkg::ST_CALC: begin
        if (lastCalc) begin
          state_d = oad_pkg::ST_DONE;
        end
      end
      oad_pkg::ST_DONE: begin
        state_d = oad_pkg::ST_OPCODE;
      end
      default: begin
        state_d = oad_pkg::ST_OPCODE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= oad_pkg::ST_OPCODE;
    end else begin
      state_q <= state_d;
    end
  end

  // Calculation cycle counter, cleared outside the calculation
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      calcCnt_q <= oad_pkg::RST_CNT;
    end else if (state_q == oad_pkg::ST_CALC) begin
      calcCnt_q <= calcCnt_q + 3'h1;
    end else begin
      calcCnt_q <= oad_pkg::RST_CNT;
    end
  end

  // Capture of opcode, addressing byte and displacement bytes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      opcode_q <= oad_pkg::RST_BYTE;
      modrm_q  <= oad_pkg::RST_BYTE;
      dispLo_q <= oad_pkg::RST_BYTE;
      dispHi_q <= oad_pkg::RST_BYTE;
    end else if (accept) begin
      if (state_q == oad_pkg::ST_OPCODE && !isPrefix) begin
        opcode_q <= byteData;
        dispLo_q <= oad_pkg::RST_BYTE;
        dispHi_q <= oad_pkg::RST_BYTE;
      end else if (state_q == oad_pkg::ST_MODRM) begin
        modrm_q  <= byteData;
      end else if (state_q == oad_pkg::ST_DISPLO) begin
        dispLo_q <= byteData;
      end else if (state_q == oad_pkg::ST_DISPHI) begin
        dispHi_q <= byteData;
      end
    end
  end

  // Segment override prefix; a later prefix replaces an earlier one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      override_q    <= 1'b0;
      overrideSeg_q <= 2'h0;
    end else if (accept && state_q == oad_pkg::ST_OPCODE &&
                 isPrefix) begin
      override_q    <= 1'b1;
      overrideSeg_q <= byteData[oad_pkg::PSEG_HI:oad_pkg::PSEG_LO];
    end else if (state_q == oad_pkg::ST_DONE) begin
      override_q    <= 1'b0;
      overrideSeg_q <= 2'h0;
    end
  end

  //--------------------------------------------------------------------
  // Effective address and segment
  //--------------------------------------------------------------------
  assign disp = dispValue(modField, rmField, dispLo_q, dispHi_q);

  // Sum of base and index registers with the displacement
  always_comb begin
    eaCalc = 16'h0000;
    case (rmField)
      3'h0: eaCalc = baseReg + srcIndex + disp;
      3'h1: eaCalc = baseReg + destIndex + disp;
      3'h2: eaCalc = frameReg + srcIndex + disp;
      3'h3: eaCalc = frameReg + destIndex + disp;
      3'h4: eaCalc = srcIndex + disp;
      3'h5: eaCalc = destIndex + disp;
      3'h6: begin
        if (modField == oad_pkg::MOD_NODISP) begin
          eaCalc = disp;
        end else begin
          eaCalc = frameReg + disp;
        end
      end
      default: eaCalc = baseReg + disp;
    endcase
  end

  // String destination first, then prefix, frame rule, data segment
  always_comb begin
    if (stringDest) begin
      segCalc = oad_pkg::SEG_EXTRA;
    end else if (override_q) begin
      segCalc = oad_pkg::oad_seg_t'(overrideSeg_q);
    end else if (usesFrame(modField, rmField)) begin
      segCalc = oad_pkg::SEG_STACK;
    end else begin
      segCalc = oad_pkg::SEG_DATA;
    end
  end

  //--------------------------------------------------------------------
  // Result registers, loaded in the last calculation cycle
  //--------------------------------------------------------------------

  // Address, segment and operand kind
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ea_q     <= oad_pkg::RST_WORD;
      seg_q    <= oad_pkg::SEG_DATA;
      memOp_q  <= 1'b0;
      ovrOut_q <= 1'b0;
    end else if (lastCalc) begin
      memOp_q  <= (modField != oad_pkg::MOD_REG);
      ovrOut_q <= override_q;
      if (modField != oad_pkg::MOD_REG) begin
        ea_q  <= eaCalc;
        seg_q <= segCalc;
      end else begin
        ea_q  <= oad_pkg::RST_WORD;
        seg_q <= oad_pkg::SEG_DATA;
      end
    end
  end

  // Displacement length, immediate start and execution time
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dispCnt_q  <= 2'h0;
      immStart_q <= oad_pkg::BASE_INSN_LEN;
      cycles_q   <= oad_pkg::RST_CYC;
    end else if (lastCalc) begin
      dispCnt_q  <= dispLen(modField, rmField);
      immStart_q <= oad_pkg::BASE_INSN_LEN +
                    {1'b0, dispLen(modField, rmField)};
      if (wide && memTransfer) begin
        cycles_q <= {1'b0, byteCycles} +
                    oad_pkg::WORD_MEM_EXTRA;
      end else begin
        cycles_q <= {1'b0, byteCycles};
      end
    end
  end

  // Register operand selections
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regIndex_q <= 3'h0;
      regHigh_q  <= 1'b0;
      regByte_q  <= 1'b0;
      rmIndex_q  <= 3'h0;
      rmHigh_q   <= 1'b0;
      rmByte_q   <= 1'b0;
    end else if (lastCalc) begin
      regIndex_q <= selRegIndex;
      regHigh_q  <= selRegHigh;
      regByte_q  <= selRegByte;
      rmIndex_q  <= selRmIndex;
      rmHigh_q   <= selRmHigh;
      rmByte_q   <= selRmByte;
    end
  end

  // Completion pulse, one cycle with the results
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= lastCalc;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign decodeDone       = done_q;
  assign opcode           = opcode_q;
  assign effectiveAddress = ea_q;
  assign segSelect        = seg_q;
  assign memOperand       = memOp_q;
  assign overrideSeen     = ovrOut_q;
  assign dispCount        = dispCnt_q;
  assign immStart         = immStart_q;
  assign execCycles       = cycles_q;
  assign regIndex         = regIndex_q;
  assign regHigh          = regHigh_q;
  assign regByte          = regByte_q;
  assign rmIndex          = rmIndex_q;
  assign rmHigh           = rmHigh_q;
  assign rmByte           = rmByte_q;

endmodule : oad_operand_decoder

// ==== tb/oad_operand_decoder_sva.sv ====
// Purpose: Port assertions for the operand address decoder
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the decoder after the module

`timescale 1ns/1ps

module oad_operand_decoder_sva (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // Inputs used by the calculation
  input wire logic              memTransfer,
  input wire logic              stringDest,
  input wire logic [7:0]        byteCycles,
  // Observed results
  input wire logic              byteReady,
  input wire logic              decodeDone,
  input wire logic [7:0]        opcode,
  input wire logic [15:0]       effectiveAddress,
  input wire oad_pkg::oad_seg_t segSelect,
  input wire logic              memOperand,
  input wire logic              overrideSeen,
  input wire logic [1:0]        dispCount,
  input wire logic [2:0]        immStart,
  input wire logic [8:0]        execCycles,
  input wire logic              rmHigh,
  input wire logic              rmByte
);
  //--------------------------------------------------------------------
  // Timing and result checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Four busy cycles, then the done cycle, then ready again
  sequence calcPhase;
    (!byteReady && !decodeDone) [*4];
  endsequence
  sequence doneThenReady;
    (decodeDone && !byteReady) ##1 (byteReady && !decodeDone);
  endsequence

  chk_calc_four_cycles: assert property (
    $fell(byteReady) |-> calcPhase ##1 doneThenReady)
    else $error("address calculation length wrong");
  chk_imm_start: assert property (
    decodeDone |-> immStart == 3'h2 + {1'h0, dispCount})
    else $error("immediate start index wrong");
  chk_reg_form: assert property (
    decodeDone && !memOperand |-> effectiveAddress == 16'h0000
      && dispCount == 2'h0 && segSelect == oad_pkg::SEG_DATA)
    else $error("register form result wrong");
  chk_exec_add: assert property (
    decodeDone |-> execCycles == {1'h0, $past(byteCycles)}
      + ((opcode[0] && $past(memTransfer)) ? 9'h004 : 9'h000))
    else $error("execution cycle count wrong");
  chk_string_extra: assert property (
    decodeDone && memOperand && $past(stringDest)
      |-> segSelect == oad_pkg::SEG_EXTRA)
    else $error("string destination segment wrong");
  chk_default_seg: assert property (
    decodeDone && memOperand && !overrideSeen && !$past(stringDest)
      |-> segSelect inside {oad_pkg::SEG_STACK, oad_pkg::SEG_DATA})
    else $error("default segment wrong");
  chk_rm_width: assert property (
    decodeDone && !memOperand
      |-> rmByte == !opcode[0] && !(opcode[0] && rmHigh))
    else $error("register width decode wrong");
  chk_results_hold: assert property (
    $changed(effectiveAddress) || $changed(execCycles) |-> decodeDone)
    else $error("results changed without done");
endmodule : oad_operand_decoder_sva

bind oad_operand_decoder oad_operand_decoder_sva i_oad_operand_decoder_sva (
  .clk, .reset_n, .memTransfer, .stringDest, .byteCycles, .byteReady,
  .decodeDone, .opcode, .effectiveAddress, .segSelect, .memOperand,
  .overrideSeen, .dispCount, .immStart, .execCycles, .rmHigh, .rmByte);

// ==== tb/oad_operand_decoder_tb.sv ====
// Purpose: Self-checking bench for the operand address decoder
// Assumes: One byte offered per handshake, no immediates sent
// Notes:   Assertions come from the bound checker

`timescale 1ns/1ps

module oad_operand_decoder_tb;
  //--------------------------------------------------------------------
  // Signals
  //--------------------------------------------------------------------
  logic              clk = 1'h0, reset_n = 1'h0, byteValid = 1'h0;
  logic              stringDest = 1'h0, memTransfer = 1'h0;
  logic [7:0]        byteData = 8'h00, byteCycles = 8'h10;
  logic [15:0]       baseReg = 16'hF200, frameReg = 16'h3400;
  logic [15:0]       srcIndex = 16'h0E56, destIndex = 16'h0078;
  logic              byteReady, decodeDone, memOperand, overrideSeen;
  logic              regHigh, regByte, rmHigh, rmByte;
  logic [7:0]        opcode;
  logic [15:0]       effectiveAddress;
  oad_pkg::oad_seg_t segSelect;
  logic [1:0]        dispCount;
  logic [2:0]        immStart, regIndex, rmIndex;
  logic [8:0]        execCycles;
  int                fails = 0, n_compared = 0;

  oad_operand_decoder i_oad_operand_decoder (.clk, .reset_n, .byteValid,
    .byteData, .byteReady, .baseReg, .frameReg, .srcIndex, .destIndex,
    .stringDest, .memTransfer, .byteCycles, .decodeDone, .opcode,
    .effectiveAddress, .segSelect, .memOperand, .overrideSeen, .dispCount,
    .immStart, .execCycles, .regIndex, .regHigh, .regByte, .rmIndex,
    .rmHigh, .rmByte);

  // Clock at 100 MHz
  always #5 clk = ~clk;

  //--------------------------------------------------------------------
  // Shared tasks
  //--------------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : check

  // Offer one byte and hold it until it is taken; ready is looked at
  // mid-cycle so the edge that takes the byte is the one waited for
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    byteValid <= 1'h1;
    byteData  <= b;
    @(negedge clk);
    while (byteReady !== 1'h1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask : put

  // Send one instruction and wait for its done pulse
  task automatic insn(input logic [7:0] pf, op, md,
                      input logic [15:0] dp, input int nd);
    int n;
    if (pf != 8'h00) put(pf);
    put(op);
    put(md);
    if (nd > 0) put(dp[7:0]);
    if (nd > 1) put(dp[15:8]);
    byteValid <= 1'h0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (decodeDone !== 1'h1 && n < 20);
    check("doneDelay", 16'h0005, 16'(n));
    @(posedge clk);
  endtask : insn

  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  // Each prefix code, string override, last of two prefixes
  task automatic t_seg();
    for (int s = 0; s < 4; s++) begin
      insn({3'h1, 2'(s), 3'h6}, 8'h8B, 8'h02, 16'h0000, 0);
      check("segSelect", 16'(s), 16'(segSelect));
      check("overrideSeen", 16'h0001, 16'(overrideSeen));
    end
    stringDest <= 1'h1;
    insn(8'h2E, 8'h8B, 8'h05, 16'h0000, 0);
    check("stringSeg", 16'h0000, 16'(segSelect));
    stringDest <= 1'h0;
    put(8'h36);
    insn(8'h3E, 8'h8B, 8'h02, 16'h0000, 0);
    check("lastPrefix", 16'h0003, 16'(segSelect));
    $display("t_seg done");
  endtask : t_seg

  // Every memory form and select code
  task automatic t_mem();
    logic [15:0] ea, d;
    int          nd;
    for (int m = 0; m < 3; m++) begin
      for (int r = 0; r < 8; r++) begin
        d  = (m == 1) ? 16'hFF9C : ((m == 2 || r == 6) ? 16'h8123 : 16'h0);
        nd = (m == 1) ? 1 : ((m == 2 || r == 6) ? 2 : 0);
        case (r)
          0: ea = baseReg + srcIndex;
          1: ea = baseReg + destIndex;
          2: ea = frameReg + srcIndex;
          3: ea = frameReg + destIndex;
          4: ea = srcIndex;
          5: ea = destIndex;
          6: ea = (m == 0) ? 16'h0000 : frameReg;
          default: ea = baseReg;
        endcase
        insn(8'h00, 8'h8B, {2'(m), 3'h2, 3'(r)}, d, nd);
        check("ea", ea + d, effectiveAddress);
        check("dispCount", 16'(nd), 16'(dispCount));
        check("noOverride", 16'h0000, 16'(overrideSeen));
        check("immStart", 16'(nd + 2), 16'(immStart));
        check("seg", (r == 2 || r == 3 || (r == 6 && m != 0)) ?
              16'h0002 : 16'h0003, 16'(segSelect));
      end
    end
    $display("t_mem done");
  endtask : t_mem

  // Register form in both widths, all codes
  task automatic t_reg();
    logic [2:0] c, k;
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 8; i++) begin
        c = 3'(i);
        k = ~c;
        insn(8'h00, {7'h44, 1'(w)}, {2'h3, c, k}, 16'h0000, 0);
        check("memOperand", 16'h0000, 16'(memOperand));
        check("opcode", 16'({7'h44, 1'(w)}), 16'(opcode));
        check("regSel", 16'({w ? c : {1'h0, c[1:0]}, w == 0 && c[2],
              w == 0}), 16'({regIndex, regHigh, regByte}));
        check("rmSel", 16'({w ? k : {1'h0, k[1:0]}, w == 0 && k[2],
              w == 0}), 16'({rmIndex, rmHigh, rmByte}));
      end
    end
    $display("t_reg done");
  endtask : t_reg

  // Word memory transfers add four cycles
  task automatic t_cyc();
    byteCycles <= 8'hFE;
    for (int k = 0; k < 4; k++) begin
      memTransfer <= k[1];
      insn(8'h00, {7'h44, k[0]}, 8'h07, 16'h0000, 0);
      check("execCycles", (k == 3) ? 16'h0102 : 16'h00FE,
            16'(execCycles));
    end
    $display("t_cyc done");
  endtask : t_cyc

  //--------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  //--------------------------------------------------------------------
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Cut a hang short well beyond the expected run
  initial begin
    #50us;
    fails++;
    end_of_test();
  end

  // Reset, then each scenario in turn
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'h1;
    check("resetSeg", 16'h0003, 16'(segSelect));
    check("resetImm", 16'h0002, 16'(immStart));
    t_seg();
    t_mem();
    t_reg();
    t_cyc();
    end_of_test();
  end
endmodule : oad_operand_decoder_tb
